/* File: arb_pkg.sv */
package arb_pkg;

  // Requester count: index 0 is the internal bridge, 1 to 8 the masters.
  localparam int NREQ = 9;

  // Register byte offsets on the configuration port.
  localparam logic [7:0] MODE_OFFSET = 8'h48;
  localparam logic [7:0] STATUS_OFFSET = 8'h60;

  // Field positions in the mode and priority word.
  localparam int EN_LSB = 1;
  localparam int EN_MSB = 8;
  localparam int EXT_BIT = 9;
  localparam int BMTO_BIT = 10;
  localparam int BMRF_BIT = 11;
  localparam int FAIR_LSB = 12;
  localparam int FAIR_MSB = 19;
  localparam int TOGGLE_BIT = 20;
  localparam int PRIO_LSB = 22;
  localparam int PRIO_MSB = 30;

  // Field positions in the status word.
  localparam int ST_BROKEN_LSB = 0;
  localparam int ST_LOCK_LSB = 8;
  localparam int ST_OWNER_LSB = 16;
  localparam int ST_ACTIVE_BIT = 20;

  // Reset values.
  localparam logic [7:0] EN_RST = 8'hff;
  localparam logic BMTO_RST = 1'b0;
  localparam logic BMRF_RST = 1'b0;
  localparam logic [7:0] FAIR_RST = 8'h08;
  localparam logic TOGGLE_RST = 1'b0;
  localparam logic [8:0] PRIO_RST = 9'h001;

  // Timing counts in secondary bus clocks.
  localparam logic [4:0] BM_CYCLES = 5'h10;
  localparam logic [1:0] TOGGLE_DELAY = 2'h2;

  // Configuration port request.
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  // Secondary bus signals seen by the arbiter, all active low.
  typedef struct packed {
    logic [8:0] req_b;
    logic frame_b;
    logic irdy_b;
  } pci_bus_s;

  typedef enum {ST_IDLE, ST_GRANT, ST_OWN, ST_TURN} arb_state_e;

endpackage

/* File: broken_tracker.sv */
`timescale 1ns/1ps

// Tracks the broken state of one external master.
module broken_tracker #(
  parameter int IDX = 1
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic mark_in,
  input wire logic req_b_in,
  input wire logic refresh_en_in,
  input wire logic [8:0] grant_pulse_in,
  input wire logic [8:0] enabled_in,
  output logic broken_out,
  output logic lock_out
);

  logic [8:0] served;
  logic all_served;

  // Every other enabled requester has had one new grant since the mark.
  assign all_served = &(served | ~enabled_in | (9'h001 << IDX));

  // Collects grants to the other requesters after the master is marked.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      served <= 9'h000;
    end else if (mark_in) begin
      served <= 9'h000;
    end else begin
      served <= served | grant_pulse_in;
    end
  end

  // A new mark wins over a refresh in the same cycle.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      broken_out <= 1'b0;
    end else if (mark_in) begin
      broken_out <= 1'b1;
    end else if (refresh_en_in && all_served) begin
      broken_out <= 1'b0;
    end
  end

  // Without refresh, a released request makes the exclusion permanent.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lock_out <= 1'b0;
    end else if (broken_out && !refresh_en_in && req_b_in) begin
      lock_out <= 1'b1;
    end
  end

endmodule

/* File: secondary_pci_bus_arbiter.sv */
`timescale 1ns/1ps

module secondary_pci_bus_arbiter (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire arb_pkg::reg_req_s reg_in,
  output logic [31:0] reg_rdata_out,
  input wire arb_pkg::pci_bus_s bus_in,
  input wire logic arbiter_select_strap_in,
  input wire logic ext_gnt_b_in,
  output logic [8:0] gnt_b_out
);

  logic ext_arb;
  logic bm_to_en;
  logic bm_rf_en;
  logic [7:0] fair_init;
  logic toggle_en;
  logic [8:0] prio;
  logic [7:0] arb_en;
  logic mode_wr;

  arb_pkg::arb_state_e state;
  arb_pkg::arb_state_e next_state;
  logic [3:0] owner;
  logic [3:0] next_owner;
  logic frame_prev;
  logic frame_fall;
  logic bus_idle;
  logic [4:0] bm_cnt;
  logic [7:0] fair_cnt;
  logic fair_armed;
  logic [1:0] tog_cnt;
  logic toggle_drop;
  logic [8:0] en_vec;
  logic [8:0] excl;
  logic [8:0] elig;
  logic [8:0] owner_hot;
  logic owner_req;
  logic other_req;
  logic fair_expire;
  logic bm_expire;
  logic new_grant;
  logic [8:0] grant_pulse;
  logic [8:0] next_gnt_b;
  logic hi_found;
  logic lo_found;
  logic [3:0] hi_idx;
  logic [3:0] lo_idx;
  logic [3:0] scan_idx;
  logic [8:0] broken;
  logic [8:0] lock;

  assign mode_wr = reg_in.wr && (reg_in.addr == arb_pkg::MODE_OFFSET);

  // The strap is followed directly, so no grant can slip out after reset.
  assign ext_arb = arbiter_select_strap_in;

  // Writable fields of the mode and priority word.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      arb_en <= arb_pkg::EN_RST;
      bm_to_en <= arb_pkg::BMTO_RST;
      bm_rf_en <= arb_pkg::BMRF_RST;
      fair_init <= arb_pkg::FAIR_RST;
      toggle_en <= arb_pkg::TOGGLE_RST;
      prio <= arb_pkg::PRIO_RST;
    end else if (mode_wr) begin
      arb_en <= reg_in.wdata[arb_pkg::EN_MSB:arb_pkg::EN_LSB];
      bm_to_en <= reg_in.wdata[arb_pkg::BMTO_BIT];
      bm_rf_en <= reg_in.wdata[arb_pkg::BMRF_BIT];
      fair_init <= reg_in.wdata[arb_pkg::FAIR_MSB:arb_pkg::FAIR_LSB];
      toggle_en <= reg_in.wdata[arb_pkg::TOGGLE_BIT];
      prio <= reg_in.wdata[arb_pkg::PRIO_MSB:arb_pkg::PRIO_LSB];
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (reg_in.rd && reg_in.addr == arb_pkg::MODE_OFFSET) begin
      reg_rdata_out <= {1'b0, prio, 1'b0, toggle_en, fair_init, bm_rf_en,
                        bm_to_en, ext_arb, arb_en, 1'b0};
    end else if (reg_in.rd && reg_in.addr == arb_pkg::STATUS_OFFSET) begin
      reg_rdata_out <= {11'h000, state != arb_pkg::ST_IDLE, owner,
                        lock[8:1], broken[8:1]};
    end else begin
      reg_rdata_out <= 32'h0000_0000;
    end
  end

  // Frame edge and bus idle detection.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      frame_prev <= 1'b1;
    end else begin
      frame_prev <= bus_in.frame_b;
    end
  end

  assign frame_fall = frame_prev && !bus_in.frame_b;
  assign bus_idle = bus_in.frame_b && bus_in.irdy_b;

  // Requesters that may win: enabled and not excluded as broken.
  assign en_vec = {arb_en, 1'b1};
  assign excl = broken | lock;
  assign elig = ~bus_in.req_b & en_vec & ~excl;
  assign owner_hot = 9'h001 << owner;
  assign owner_req = |(~bus_in.req_b & en_vec & owner_hot);
  assign other_req = |(elig & ~owner_hot);

  // Rotating search from the last owner, high priority class first.
  always_comb begin
    hi_found = 1'b0;
    lo_found = 1'b0;
    hi_idx = 4'h0;
    lo_idx = 4'h0;
    scan_idx = owner;
    for (int k = 0; k < arb_pkg::NREQ; k++) begin
      scan_idx = (scan_idx == 4'h8) ? 4'h0 : scan_idx + 4'h1;
      if (elig[scan_idx] && prio[scan_idx] && !hi_found) begin
        hi_found = 1'b1;
        hi_idx = scan_idx;
      end
      if (elig[scan_idx] && !prio[scan_idx] && !lo_found) begin
        lo_found = 1'b1;
        lo_idx = scan_idx;
      end
    end
  end

  // Fairness expiry never fires with a zero load value.
  assign fair_expire = fair_armed && (fair_init != 8'h00) && other_req &&
                       (fair_cnt == 8'h00);
  assign bm_expire = bm_to_en && (state == arb_pkg::ST_GRANT) && bus_idle &&
                     !frame_fall &&
                     (bm_cnt == arb_pkg::BM_CYCLES - 5'h01);

  // Grant sequencing: idle, granted, owned, one turnaround cycle.
  always_comb begin
    next_state = state;
    next_owner = owner;
    case (state)
      arb_pkg::ST_IDLE: begin
        if (!ext_arb && hi_found) begin
          next_state = arb_pkg::ST_GRANT;
          next_owner = hi_idx;
        end else if (!ext_arb && lo_found) begin
          next_state = arb_pkg::ST_GRANT;
          next_owner = lo_idx;
        end
      end
      arb_pkg::ST_GRANT: begin
        if (frame_fall) begin
          next_state = arb_pkg::ST_OWN;
        end else if (bm_expire || !owner_req) begin
          next_state = arb_pkg::ST_TURN;
        end
      end
      arb_pkg::ST_OWN: begin
        if (!owner_req || fair_expire) begin
          next_state = arb_pkg::ST_TURN;
        end
      end
      arb_pkg::ST_TURN: begin
        next_state = arb_pkg::ST_IDLE;
      end
      default: begin
        next_state = arb_pkg::ST_IDLE;
      end
    endcase
    if (ext_arb) begin
      next_state = arb_pkg::ST_IDLE;
    end
  end

  assign new_grant = (state == arb_pkg::ST_IDLE) &&
                     (next_state == arb_pkg::ST_GRANT);
  assign grant_pulse = new_grant ? (9'h001 << next_owner) : 9'h000;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= arb_pkg::ST_IDLE;
      owner <= 4'h0;
    end else begin
      state <= next_state;
      owner <= next_owner;
    end
  end

  // Broken-master window counts idle cycles while waiting for frame.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bm_cnt <= 5'h00;
    end else if (!bm_to_en || state != arb_pkg::ST_GRANT) begin
      bm_cnt <= 5'h00;
    end else if (bus_idle) begin
      bm_cnt <= bm_cnt + 5'h01;
    end
  end

  // Fairness counter: reloaded per grant, armed by the next frame fall.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fair_cnt <= arb_pkg::FAIR_RST;
      fair_armed <= 1'b0;
    end else if (new_grant) begin
      fair_cnt <= fair_init;
      fair_armed <= 1'b0;
    end else if (!fair_armed) begin
      fair_armed <= frame_fall && state == arb_pkg::ST_GRANT;
    end else if (other_req && fair_cnt != 8'h00) begin
      fair_cnt <= fair_cnt - 8'h01;
    end
  end

  // Toggle delay counter started by the owner's frame fall.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tog_cnt <= 2'h0;
    end else if (toggle_en && frame_fall && state == arb_pkg::ST_GRANT) begin
      tog_cnt <= arb_pkg::TOGGLE_DELAY;
    end else if (tog_cnt != 2'h0) begin
      tog_cnt <= tog_cnt - 2'h1;
    end
  end

  assign toggle_drop = toggle_en && (tog_cnt == 2'h1);

  // Grant lines are registered; external mode only relays the bridge grant.
  always_comb begin
    next_gnt_b = 9'h1ff;
    if (ext_arb) begin
      next_gnt_b[0] = ext_gnt_b_in;
    end else if ((next_state == arb_pkg::ST_GRANT ||
                  next_state == arb_pkg::ST_OWN) && !toggle_drop) begin
      next_gnt_b = ~(9'h001 << next_owner);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gnt_b_out <= 9'h1ff;
    end else begin
      gnt_b_out <= next_gnt_b;
    end
  end

  // The internal bridge is never marked broken.
  assign broken[0] = 1'b0;
  assign lock[0] = 1'b0;

  // One broken-state tracker per external master.
  for (genvar i = 1; i < arb_pkg::NREQ; i++) begin : g_track
    broken_tracker #(.IDX(i)) u_track (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .mark_in(bm_expire && owner == 4'(i)),
      .req_b_in(bus_in.req_b[i]),
      .refresh_en_in(bm_rf_en),
      .grant_pulse_in(grant_pulse),
      .enabled_in(en_vec),
      .broken_out(broken[i]),
      .lock_out(lock[i])
    );
  end

  a_strap_readback: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    reg_in.rd && reg_in.addr == arb_pkg::MODE_OFFSET |=>
      reg_rdata_out[arb_pkg::EXT_BIT] == $past(arbiter_select_strap_in))
    else $error("arbiter select status does not follow strap");

  a_broken_drop: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    bm_expire && !ext_arb |=> gnt_b_out[$past(owner)]
      ##1 state == arb_pkg::ST_IDLE)
    else $error("grant kept after broken master timeout");

  a_timeout_idle: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    !bm_to_en |=> bm_cnt == 5'h00)
    else $error("broken master count runs while disabled");

  a_fair_reload: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    new_grant |=> fair_cnt == $past(fair_init) && !fair_armed)
    else $error("fairness counter not reloaded on new grant");

  a_fair_wait: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    !fair_armed && !new_grant |=> fair_cnt == $past(fair_cnt))
    else $error("fairness counter moved before frame fall");

  a_zero_fair_hold: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    state == arb_pkg::ST_OWN && fair_init == 8'h00 && owner_req && !ext_arb
      |=> state == arb_pkg::ST_OWN)
    else $error("grant removed with zero fairness while request held");

  a_no_toggle: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    !toggle_en && !ext_arb && state == arb_pkg::ST_OWN &&
      next_state == arb_pkg::ST_OWN |=> !gnt_b_out[$past(owner)])
    else $error("grant dropped with toggling disabled");

  a_toggle_gap: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    toggle_en && !ext_arb && state == arb_pkg::ST_GRANT && frame_fall &&
      !mode_wr |-> ##3 (&gnt_b_out))
    else $error("grant not dropped for one clock after frame");

  a_prio_readback: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    reg_in.rd && reg_in.addr == arb_pkg::MODE_OFFSET |=>
      reg_rdata_out[arb_pkg::PRIO_MSB:arb_pkg::PRIO_LSB] == $past(prio))
    else $error("priority field readback mismatch");

  a_ext_quiet: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    ext_arb |=> (&gnt_b_out[8:1]) && gnt_b_out[0] == $past(ext_gnt_b_in))
    else $error("internal grant driven while external arbiter selected");

  a_disabled_quiet: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    state == arb_pkg::ST_IDLE |=> (~gnt_b_out & ~$past(en_vec)) == 9'h000)
    else $error("new grant given to a disabled master");

  a_locked_out: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (~gnt_b_out & $past(lock)) == 9'h000)
    else $error("grant given to a locked broken master");

endmodule

/* File: bus_master_model.sv */
`timescale 1ns/1ps

// Behavioural set of secondary bus requesters, the bridge at index 0.
module bus_master_model (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [8:0] want_in,
  input wire logic [4:0] wait_in,
  input wire logic [8:0] gnt_b_in,
  output arb_pkg::pci_bus_s bus_out
);
  logic [4:0] cnt;
  logic [8:0] own;

  // Requests follow want; a granted requester starts its frame after
  // wait_in clocks (1fh means never) and ends it once it stops wanting.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bus_out <= '1;
      cnt <= 5'h00;
      own <= 9'h000;
    end else begin
      bus_out.req_b <= ~want_in;
      if (own != 9'h000) begin
        if ((own & want_in) == 9'h000) begin
          own <= 9'h000;
          bus_out.frame_b <= 1'b1;
          bus_out.irdy_b <= 1'b1;
        end
      end else if ((~gnt_b_in & want_in) != 9'h000 && wait_in != 5'h1f) begin
        if (cnt == wait_in) begin
          own <= ~gnt_b_in & want_in;
          bus_out.frame_b <= 1'b0;
          bus_out.irdy_b <= 1'b0;
          cnt <= 5'h00;
        end else begin
          cnt <= cnt + 5'h01;
        end
      end else begin
        cnt <= 5'h00;
      end
    end
  end
endmodule

/* File: secondary_pci_bus_arbiter_tb_top.sv */
`timescale 1ns/1ps

module secondary_pci_bus_arbiter_tb_top;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  arb_pkg::reg_req_s reg_in = '0;
  logic [31:0] rdata;
  arb_pkg::pci_bus_s bus;
  logic strap = 1'b0;
  logic ext_gnt_b = 1'b1;
  logic [8:0] gnt_b;
  logic [8:0] want = 9'h000;
  logic [4:0] wait_c = 5'h01;
  logic [31:0] d;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;
  int k;

  // Free-running 100 MHz clock.
  always #5 clk_in = ~clk_in;

  secondary_pci_bus_arbiter dut_u (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .reg_in(reg_in),
    .reg_rdata_out(rdata),
    .bus_in(bus),
    .arbiter_select_strap_in(strap),
    .ext_gnt_b_in(ext_gnt_b),
    .gnt_b_out(gnt_b)
  );

  bus_master_model master_u (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .want_in(want),
    .wait_in(wait_c),
    .gnt_b_in(gnt_b),
    .bus_out(bus)
  );

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("mismatches %0d, checks %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write of the mode word.
  task automatic wmode(input logic [31:0] v);
    @(posedge clk_in);
    reg_in <= '{addr: arb_pkg::MODE_OFFSET, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    reg_in.wr <= 1'b0;
  endtask

  // One-cycle read; data is taken in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_in);
    reg_in <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    reg_in.rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  function automatic logic [31:0] mode(logic t, logic [7:0] f, logic g);
    return 32'h004001fe | ({31'h0, t} << 10) | ({24'h0, f} << 12)
      | ({31'h0, g} << 20);
  endfunction

  task automatic set_want(input logic [8:0] v);
    @(posedge clk_in);
    want <= v;
  endtask

  // Waits a bounded time for grant i to reach level v.
  task automatic wait_gnt(input int i, input logic v, input int n);
    #1;
    k = 0;
    while (gnt_b[i] !== v && k < n) begin
      @(posedge clk_in);
      #1;
      k++;
    end
    chk({31'h0, gnt_b[i]}, {31'h0, v});
  endtask

  // Counts the clocks among the next n where grant i is not at level v.
  task automatic cnt_gnt(input int i, input logic v, input int n);
    k = 0;
    repeat (n) begin
      @(posedge clk_in);
      #1;
      if (gnt_b[i] !== v) k++;
    end
  endtask

  task automatic do_reset();
    rst_b_in <= 1'b0;
    want <= 9'h000;
    repeat (20) @(posedge clk_in);
    rst_b_in <= 1'b1;
  endtask

  task automatic idle();
    set_want(9'h000);
    repeat (6) @(posedge clk_in);
  endtask

  // Cuts a hung run short.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  initial begin
    do_reset();
    // Reset image, writable bits, unmapped place.
    rd(arb_pkg::MODE_OFFSET, d);
    chk(d, 32'h004081fe);
    wmode(32'hffffffff);
    rd(arb_pkg::MODE_OFFSET, d);
    chk(d, 32'h7fdffdfe);
    rd(8'h50, d);
    chk(d, 32'h0);
    // Bridge at high priority wins over master 7 at low priority.
    wmode(mode(1'b0, 8'h00, 1'b0));
    set_want(9'h081);
    wait_gnt(0, 1'b0, 6);
    chk({31'h0, gnt_b[7]}, 32'h1);
    idle();
    // Fairness 00h keeps the grant while a competitor waits.
    set_want(9'h002);
    wait_gnt(1, 1'b0, 6);
    set_want(9'h006);
    cnt_gnt(1, 1'b0, 40);
    chk(k, 0);
    set_want(9'h004);
    wait_gnt(2, 1'b0, 8);
    idle();
    // Fairness 4 holds a few clocks, then moves the grant on.
    wmode(mode(1'b0, 8'h04, 1'b0));
    set_want(9'h002);
    wait_gnt(1, 1'b0, 6);
    repeat (3) @(posedge clk_in);
    set_want(9'h006);
    cnt_gnt(1, 1'b0, 4);
    chk(k, 0);
    wait_gnt(1, 1'b1, 14);
    set_want(9'h004);
    wait_gnt(2, 1'b0, 8);
    idle();
    // Toggling drops the grant for exactly one clock.
    wmode(mode(1'b0, 8'h00, 1'b1));
    set_want(9'h010);
    wait_gnt(4, 1'b0, 6);
    cnt_gnt(4, 1'b0, 12);
    chk(k, 1);
    idle();
    // A master that never starts a frame, timeout off then on.
    wmode(mode(1'b0, 8'h00, 1'b0));
    wait_c <= 5'h1f;
    set_want(9'h040);
    wait_gnt(6, 1'b0, 6);
    cnt_gnt(6, 1'b0, 30);
    chk(k, 0);
    idle();
    wmode(mode(1'b1, 8'h00, 1'b0));
    set_want(9'h020);
    wait_gnt(5, 1'b0, 6);
    cnt_gnt(5, 1'b0, 14);
    chk(k, 0);
    wait_gnt(5, 1'b1, 6);
    rd(arb_pkg::STATUS_OFFSET, d);
    chk({31'h0, d[4]}, 32'h1);
    // Without refresh a released broken master stays out.
    set_want(9'h000);
    repeat (3) @(posedge clk_in);
    set_want(9'h020);
    cnt_gnt(5, 1'b1, 30);
    chk(k, 0);
    rd(arb_pkg::STATUS_OFFSET, d);
    chk({31'h0, d[12]}, 32'h1);
    // Refresh on, timeout on, only masters 1 and 3 enabled.
    wmode(32'h00400c0a);
    set_want(9'h004);
    cnt_gnt(2, 1'b1, 10);
    chk(k, 0);
    wait_c <= 5'h1f;
    set_want(9'h008);
    wait_gnt(3, 1'b0, 6);
    wait_gnt(3, 1'b1, 24);
    rd(arb_pkg::STATUS_OFFSET, d);
    chk({31'h0, d[2]}, 32'h1);
    // Bridge and master 1 served once clear the broken mark.
    wait_c <= 5'h01;
    set_want(9'h009);
    wait_gnt(0, 1'b0, 8);
    set_want(9'h00a);
    wait_gnt(1, 1'b0, 8);
    rd(arb_pkg::STATUS_OFFSET, d);
    chk({27'h0, d[20:16]}, 32'h11);
    chk({31'h0, d[2]}, 32'h0);
    set_want(9'h008);
    wait_gnt(3, 1'b0, 10);
    // External arbiter: only the bridge grant, taken from outside.
    @(posedge clk_in);
    wait_c <= 5'h01;
    strap <= 1'b1;
    ext_gnt_b <= 1'b0;
    do_reset();
    set_want(9'h1fe);
    repeat (4) @(posedge clk_in);
    #1;
    chk({23'h0, gnt_b}, 32'h1fe);
    rd(arb_pkg::MODE_OFFSET, d);
    chk({31'h0, d[9]}, 32'h1);
    report_and_stop();
  end
endmodule
